// ==== logic/sdcp_defines.vh ====
/*
 * constants for the sdram clock-suspend / low-power-idle block.
 * assumes inclusion by bare name from logic/ and bench/ sources.
 */
`ifndef SDCP_DEFINES_VH
`define SDCP_DEFINES_VH

// data path
`define SDCP_DW            16
`define SDCP_BANKS         4
// clock rate and timing
`define SDCP_CLK_MHZ       20
`define SDCP_TIS_PS        1500
`define SDCP_TCK_PS        50000
// exit set-up in whole cycles: ceil((tis + tck) / tck)
`define SDCP_TPDE_CYC      ((`SDCP_TIS_PS + `SDCP_TCK_PS + `SDCP_TCK_PS - 1) / `SDCP_TCK_PS)
`define SDCP_TPDE_W        2
// read output disable latency in cycles
`define SDCP_DQM_RD_LAT    2
// states
`define SDCP_ST_RUN        2'h0
`define SDCP_ST_SUSP       2'h1
`define SDCP_ST_LPI        2'h2
`define SDCP_ST_EXIT       2'h3
// command codes {ras_n, cas_n, we_n}
`define SDCP_CMD_NOP       3'h7

`endif

// ==== logic/sdcp_delay.v ====
/*
 * small shift delay line of one bit, run only while the internal clock
 * is enabled, so a suspend holds it frozen.
 * assumes one clock, synchronous active-high reset.
 */
`timescale 1ns/1ps
`default_nettype none
module sdcp_delay #(
    parameter DEPTH = 2
) (
    input  wire i_clk,
    input  wire i_rst,
    input  wire i_adv,
    input  wire i_d,
    input  wire i_rst_val,
    output wire o_q
);
    reg [DEPTH-1:0] sh_reg;

    // shift only on enabled internal edges
    always @(posedge i_clk) begin
        if (i_rst) begin
            sh_reg <= {DEPTH{i_rst_val}};
        end else if (i_adv) begin
            sh_reg <= {sh_reg[DEPTH-2:0], i_d};
        end
    end

    assign o_q = sh_reg[DEPTH-1];
endmodule
`default_nettype wire

// ==== logic/sdcp_core.v ====
/*
 * clock suspend, low-power idle and dqm control for an sdram die.
 * assumes the controller drives cke, dqm and command pins synchronous
 * to i_clk; bank and burst state come from the rest of the die.
 */
`timescale 1ns/1ps
`default_nettype none
`include "sdcp_defines.vh"
module sdcp_core (
    input  wire                    i_clk,
    input  wire                    i_rst,
    input  wire                    i_cke,
    input  wire                    i_dqm,
    input  wire                    i_cs_n,
    input  wire                    i_ras_n,
    input  wire                    i_cas_n,
    input  wire                    i_we_n,
    input  wire [`SDCP_BANKS-1:0]  i_bank_active,
    input  wire                    i_wr_burst,
    input  wire                    i_rd_burst,
    input  wire [`SDCP_DW-1:0]     i_rd_data,
    input  wire [`SDCP_DW-1:0]     i_dq_in,
    output wire                    o_int_clk_en,
    output wire                    o_low_power_idle_state,
    output wire                    o_buf_en,
    output wire                    o_cmd_valid,
    output wire [2:0]              o_cmd,
    output reg                     o_wr_en,
    output reg  [`SDCP_DW-1:0]     o_wr_data,
    output reg  [`SDCP_DW-1:0]     o_dq_out,
    output wire                    o_dq_oe_n,
    output wire                    o_exit_busy
);
    reg  [1:0]              state_reg;
    reg  [1:0]              state_next;
    reg  [`SDCP_TPDE_W-1:0] cnt_reg;
    reg  [`SDCP_TPDE_W-1:0] cnt_next;
    wire                    all_idle;
    wire                    in_burst;
    wire                    run;
    wire                    selected;
    wire                    rd_mask_q;
    // full-width load value, cut to the counter width below on purpose
    wire [31:0]             tpde_load;

    assign tpde_load = `SDCP_TPDE_CYC - 1;

    assign all_idle = ~|i_bank_active;
    assign in_burst = i_wr_burst | i_rd_burst;
    // internal edges only in the run state
    assign run      = (state_reg == `SDCP_ST_RUN);

    // cke state machine; cke alone is looked at outside run
    always @* begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        case (state_reg)
            `SDCP_ST_RUN: begin
                if (!i_cke && !all_idle) begin
                    state_next = `SDCP_ST_SUSP;
                end else if (!i_cke) begin
                    state_next = `SDCP_ST_LPI;
                end
            end
            `SDCP_ST_SUSP: begin
                if (i_cke) begin
                    state_next = `SDCP_ST_RUN;
                end
            end
            `SDCP_ST_LPI: begin
                if (i_cke) begin
                    state_next = `SDCP_ST_EXIT;
                    cnt_next   = tpde_load[`SDCP_TPDE_W-1:0];
                end
            end
            `SDCP_ST_EXIT: begin
                // a dropped cke during set-up restarts the wait
                if (!i_cke) begin
                    state_next = `SDCP_ST_LPI;
                end else if (cnt_reg == {`SDCP_TPDE_W{1'b0}}) begin
                    state_next = `SDCP_ST_RUN;
                end else begin
                    cnt_next = cnt_reg - 1'b1;
                end
            end
            default: begin
                state_next = `SDCP_ST_RUN;
            end
        endcase
    end

    always @(posedge i_clk) begin
        if (i_rst) begin
            state_reg <= `SDCP_ST_RUN;
            cnt_reg   <= {`SDCP_TPDE_W{1'b0}};
        end else begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
        end
    end

    assign o_int_clk_en           = run;
    assign o_low_power_idle_state = (state_reg == `SDCP_ST_LPI);
    // buffers off until set-up is met, cke buffer is never gated
    assign o_buf_en    = (state_reg != `SDCP_ST_LPI) &&
                         (state_reg != `SDCP_ST_EXIT);
    assign o_exit_busy = (state_reg == `SDCP_ST_EXIT);

    // command decode: deselect or nop yields no action
    assign selected    = ~i_cs_n;
    assign o_cmd       = {i_ras_n, i_cas_n, i_we_n};
    assign o_cmd_valid = run && selected &&
                         (o_cmd != `SDCP_CMD_NOP);

    // write mask acts in the sampled cycle; write enable drops low and write data holds while suspended
    always @(posedge i_clk) begin
        if (i_rst) begin
            o_wr_en   <= 1'b0;
            o_wr_data <= {`SDCP_DW{1'b0}};
        end else begin
            o_wr_en <= run && i_wr_burst && !i_dqm;
            if (run && i_wr_burst) begin
                o_wr_data <= i_dq_in;
            end
        end
    end

    // read mask pipeline; stalls with the internal clock
    sdcp_delay #(
        .DEPTH(`SDCP_DQM_RD_LAT)
    ) u_rd_mask (
        .i_clk     (i_clk),
        .i_rst     (i_rst),
        .i_adv     (run),
        .i_d       (i_dqm | ~i_rd_burst),
        .i_rst_val (1'b1),
        .o_q       (rd_mask_q)
    );

    // read data held across a suspend
    always @(posedge i_clk) begin
        if (i_rst) begin
            o_dq_out <= {`SDCP_DW{1'b0}};
        end else if (run) begin
            o_dq_out <= i_rd_data;
        end
    end

    // high means high impedance: masked, idle or outside a read
    assign o_dq_oe_n = rd_mask_q | ~o_buf_en;
    wire unused_ok = in_burst;
endmodule
`default_nettype wire

// ==== bench/sdcp_core_monitor.sv ====
/* port assertions for sdcp_core.
   assumes one clock and a bind to each sdcp_core. */
`timescale 1ns/1ps
`default_nettype none
`include "sdcp_defines.vh"
module sdcp_core_monitor (
    input wire logic        i_clk, i_rst, i_cke, i_dqm, i_cs_n, i_ras_n,
    input wire logic        i_cas_n, i_we_n, i_wr_burst, i_rd_burst,
    input wire logic        o_int_clk_en, o_buf_en, o_low_power_idle_state,
    input wire logic        o_cmd_valid, o_wr_en, o_dq_oe_n, o_exit_busy,
    input wire logic [3:0]  i_bank_active,
    input wire logic [15:0] o_dq_out
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    // entry and exit timing, one cycle after the gate is sampled; idle exit after three high samples
    susp_entry_a:
    assert property (o_int_clk_en && !i_cke && |i_bank_active
        |=> !o_int_clk_en && !o_low_power_idle_state) else $error("susp");
    idle_entry_a:
    assert property (o_int_clk_en && !i_cke && i_bank_active == 4'h0
        |=> o_low_power_idle_state && !o_buf_en) else $error("idle");
    susp_exit_a:
    assert property (!o_int_clk_en && !o_low_power_idle_state
        && !o_exit_busy && i_cke |=> o_int_clk_en) else $error("wake");
    idle_exit_a:
    assert property (o_low_power_idle_state && i_cke ##1 i_cke [*2]
        |=> o_int_clk_en && o_buf_en) else $error("exit");
    cmd_gate_a:
    assert property (o_cmd_valid == (o_int_clk_en && !i_cs_n
        && {i_ras_n, i_cas_n, i_we_n} != `SDCP_CMD_NOP)) else $error("cmd");
    // a masked clock must not move the read word
    data_hold_a:
    assert property (!o_int_clk_en |=> $stable(o_dq_out)) else $error("hold");
    wr_mask_a:
    assert property (o_int_clk_en && i_wr_burst
        |=> o_wr_en == !$past(i_dqm)) else $error("mask");
    rd_off_a:
    assert property (o_int_clk_en && i_rd_burst && i_dqm ##1 o_int_clk_en
        |=> o_dq_oe_n) else $error("oe");
    cover property (o_low_power_idle_state && i_cke);
    cover property (!o_int_clk_en && !o_low_power_idle_state);
    cover property (o_wr_en);
endmodule
bind sdcp_core sdcp_core_monitor u_sdcp_core_monitor (.*);
`default_nettype wire

// ==== bench/sdcp_ctrl_model.sv ====
/* controller model: clock gate and command pins.
   assumes the bench calls one task at a time. */
`timescale 1ns/1ps
`default_nettype none
`include "sdcp_defines.vh"
module sdcp_ctrl_model (
    input  wire logic       i_clk,
    output var  logic       o_cke,
    output var  logic       o_cs_n,
    output var  logic [2:0] o_cmd
);
    // idle: gate high, deselected
    initial begin
        o_cke = 1'b1;
        o_cs_n = 1'b1;
        o_cmd = `SDCP_CMD_NOP;
    end
    // one command for one cycle, then a nop
    task automatic issue(input logic [3:0] c);
        @(posedge i_clk);
        {o_cs_n, o_cmd} <= c;
        @(posedge i_clk);
        {o_cs_n, o_cmd} <= {1'b0, `SDCP_CMD_NOP};
    endtask
    // short gate-low spell, far inside any refresh period
    task automatic sleep(input int n);
        @(posedge i_clk);
        o_cke <= 1'b0;
        repeat (n) @(posedge i_clk);
        o_cke <= 1'b1;
        o_cmd <= `SDCP_CMD_NOP;
        repeat (3) @(posedge i_clk);
    endtask
endmodule
`default_nettype wire

// ==== bench/sdcp_core_tb.sv ====
/* self-checking bench for sdcp_core.
   assumes the model drives gate and command pins. */
`timescale 1ns/1ps
`default_nettype none
module sdcp_core_tb;
    logic        clk = 0, rst = 1, dqm = 1, wrb = 0, rdb = 0;
    logic [3:0]  banks = 4'h0;
    logic [15:0] rdd = 16'h0, dqi = 16'h0, exp_q[$];
    logic [31:0] rnd = 32'h099700B5;
    wire         cke, cs_n, clk_en, lpi, buf_en, wr_en, busy;
    wire [2:0]   mc;
    wire [15:0]  wr_d;
    int          num_errors = 0, samples_checked = 0;
    always #25 clk = ~clk;
    sdcp_ctrl_model u_sdcp_ctrl_model (.i_clk(clk), .o_cke(cke),
        .o_cs_n(cs_n), .o_cmd(mc));
    sdcp_core u_sdcp_core (.i_clk(clk), .i_rst(rst), .i_cke(cke),
        .i_dqm(dqm), .i_cs_n(cs_n), .i_ras_n(mc[2]), .i_cas_n(mc[1]),
        .i_we_n(mc[0]), .i_bank_active(banks), .i_wr_burst(wrb),
        .i_rd_burst(rdb), .i_rd_data(rdd), .i_dq_in(dqi),
        .o_int_clk_en(clk_en), .o_low_power_idle_state(lpi),
        .o_buf_en(buf_en), .o_cmd_valid(), .o_cmd(), .o_wr_en(wr_en),
        .o_wr_data(wr_d), .o_dq_out(), .o_dq_oe_n(), .o_exit_busy(busy));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input logic [15:0] got, exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // each written word against the oldest note; empty queue never matches
    always @(negedge clk)
        if (wr_en === 1'b1) chk(wr_d, exp_q.size() ? exp_q.pop_front() : 'x);
    initial begin
        repeat (8) @(posedge clk);
        rst <= 0;
        banks <= 4'h1;
        for (int k = 0; k < 40; k++) begin
            @(posedge clk);
            rnd = lfsr(rnd);
            {wrb, rdb} <= {k < 20, k >= 20};
            {dqm, dqi, rdd} <= {rnd[0], rnd[31:16], rnd[15:0]};
            if (k < 20 && !rnd[0]) exp_q.push_back(rnd[31:16]);
            if (k == 30) u_sdcp_ctrl_model.sleep(1 + rnd[3:2]);
        end
        @(posedge clk);
        {wrb, rdb, banks} <= 6'h0;
        $display("test burst done");
        for (int c = 0; c < 16; c++) u_sdcp_ctrl_model.issue(c[3:0]);
        $display("test command done");
        fork
            u_sdcp_ctrl_model.sleep(3);
            begin
                repeat (3) @(posedge clk);
                #1 chk(lpi, 1);
                chk(buf_en, 0);
            end
        join
        @(negedge clk);
        chk({clk_en, buf_en, busy}, 3'h6);
        $display("test idle done");
        repeat (20) if (exp_q.size()) @(posedge clk);
        if (exp_q.size()) chk(exp_q.size(), 0);
        stop_test();
    end
endmodule
`default_nettype wire
